// *** sim/modbus_link_checker.sv ***
// Checker for the query link: framing, echo, counts and frame check.
// Assumes it watches the link that joins the master and slave ends.
`timescale 1ns/1ps
module modbus_link_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic qValid,
    input wire logic [7:0] qData,
    input wire logic qLast,
    input wire logic qReady,
    input wire logic rValid,
    input wire logic [7:0] rData,
    input wire logic rLast,
    input wire logic rReady
);
    import modbus_pkg::*;
    byte_t qb [0:7];
    logic [2:0] qIdx_q;
    logic [7:0] rIdx_q;
    word_t qCrc_q;
    word_t rCrc_q;
    logic qTake;
    logic rTake;
    assign qTake = qValid && qReady;
    assign rTake = rValid && rReady;

    // Independent frame check step
    function automatic word_t step(word_t c, logic [7:0] b);
        word_t x;
        x = c ^ {8'h00, b};
        repeat (8) x = x[0] ? ((x >> 1) ^ 16'hA001) : (x >> 1);
        return x;
    endfunction

    // Capture query bytes and running checks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            qIdx_q <= 3'h0;
            qCrc_q <= CRC_INIT;
        end else if (qTake) begin
            qb[qIdx_q] <= qData;
            qIdx_q <= qLast ? 3'h0 : qIdx_q + 3'h1;
            qCrc_q <= qLast ? CRC_INIT : step(qCrc_q, qData);
        end
    end

    // Count reply bytes of the current frame
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rIdx_q <= 8'h00;
            rCrc_q <= CRC_INIT;
        end else if (rTake) begin
            rIdx_q <= rLast ? 8'h00 : rIdx_q + 8'h01;
            rCrc_q <= rLast ? CRC_INIT : step(rCrc_q, rData);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    query_hold_a: assert property (qValid && !qReady |=>
        qValid && $stable(qData) && $stable(qLast))
        else $error("query byte changed before accept");
    refuse_after_last_a: assert property (qTake && qLast |=> !qReady)
        else $error("query accepted right after last byte");
    ready_return_a: assert property (qTake && qLast |-> ##[1:400] qReady)
        else $error("slave never ready again");
    query_check_a: assert property (qTake && qLast |->
        step(qCrc_q, qData) == CRC_RESIDUE)
        else $error("query frame check wrong");
    reply_addr_a: assert property (rTake && rIdx_q == 8'h00 |->
        rData == qb[0])
        else $error("reply address differs");
    reply_func_a: assert property (rTake && rIdx_q == 8'h01 |->
        rData == qb[1])
        else $error("reply function differs");
    byte_count_a: assert property (rTake && rIdx_q == 8'h02 &&
        qb[1] == FC_READ |-> rData == {qb[5][6:0], 1'b0})
        else $error("read byte count wrong");
    read_len_a: assert property (rTake && rLast && qb[1] == FC_READ |->
        rIdx_q == {qb[5][6:0], 1'b0} + 8'h04)
        else $error("read reply length wrong");
    echo_same_a: assert property (rTake && qb[1] != FC_READ |->
        rData == qb[rIdx_q[2:0]] && rLast == (rIdx_q == 8'h07))
        else $error("echo differs from query");
    bcast_silent_a: assert property (rValid |-> qb[0] != BCAST_ADDR)
        else $error("reply to broadcast");
    reply_check_a: assert property (rTake && rLast |->
        step(rCrc_q, rData) == CRC_RESIDUE)
        else $error("reply frame check wrong");
endmodule

// *** sim/tb.sv ***
// Testbench: master and slave ends face each other, plus a raw link.
// Assumes the package, the link and both ends.
`timescale 1ns/1ps
module tb;
    import modbus_pkg::*;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
    num_errors++; $display("wrong value at %0t: %h vs %h", \
    $time, (a), (b)); end end
    logic clk, rst_n, cmdValid, cmdReady, cmdReject, rspValid, rspLast;
    logic rspCrcOk, rspTimeout, wrEn;
    byte_t cmdFunc, cmdSlave, rspByte;
    logic [16:0] cmdReg;
    word_t cmdArg, regAddr, regAddr2, wrData, wrA, wrD;
    int num_errors, tests_run, cyc, nGot, wrCnt, r2Cnt;
    byte_t got [0:299];
    byte_t exp[$];
    bit sawTo;

    modbus_link_if link (.clk(clk), .rst_n(rst_n));
    modbus_link_if link2 (.clk(clk), .rst_n(rst_n));
    modbus_master_end modbus_master_end_inst (.link(link),
        .cmdValid(cmdValid), .cmdFunc(cmdFunc), .cmdSlave(cmdSlave),
        .cmdReg(cmdReg), .cmdArg(cmdArg), .cmdReady(cmdReady),
        .cmdReject(cmdReject), .rspValid(rspValid), .rspByte(rspByte),
        .rspLast(rspLast), .rspCrcOk(rspCrcOk), .rspTimeout(rspTimeout));
    modbus_slave_end modbus_slave_end_inst (.link(link),
        .ownAddr(8'h05), .regAddr(regAddr), .rdData(rdf(regAddr)),
        .wrAllow(regAddr < 16'h0100), .wrEn(wrEn), .wrData(wrData));
    // Second slave fed by the raw driver below
    modbus_slave_end modbus_slave_end_inst2 (.link(link2),
        .ownAddr(8'h05), .regAddr(regAddr2), .rdData(rdf(regAddr2)),
        .wrAllow(regAddr2 < 16'h0100), .wrEn(), .wrData());
    modbus_link_checker modbus_link_checker_inst (.clk(clk),
        .rst_n(rst_n), .qValid(link.qValid), .qData(link.qData),
        .qLast(link.qLast), .qReady(link.qReady), .rValid(link.rValid),
        .rData(link.rData), .rLast(link.rLast), .rReady(link.rReady));

    // Register contents seen by reads
    function automatic word_t rdf(word_t a);
        return a ^ 16'h5A3C;
    endfunction

    // Append the frame check to exp, low byte first
    task automatic addCrc();
        word_t c;
        c = 16'hFFFF;
        foreach (exp[i]) begin
            c ^= {8'h00, exp[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        exp.push_back(c[7:0]);
        exp.push_back(c[15:8]);
    endtask

    // Clock and watchdog
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (wrEn === 1'b1) begin
            wrCnt++;
            wrA = regAddr;
            wrD = wrData;
        end
        if ((link2.rValid & link2.rReady) === 1'b1) r2Cnt++;
        if (cyc == 60000) begin
            num_errors++;
            $display("wrong value at %0t: run too long", $time);
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Expected frame with trailing check, low byte first
    task automatic mk(byte_t a, f, word_t w1, w2);
        exp = {a, f, w1[15:8], w1[7:0], w2[15:8], w2[7:0]};
        addCrc();
    endtask

    task automatic cmd(byte_t f, s, logic [16:0] r, word_t a);
        for (int k = 0; k < 3000 && cmdReady !== 1'b1; k++) @(negedge clk);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdFunc <= f;
        cmdSlave <= s;
        cmdReg <= r;
        cmdArg <= a;
        @(posedge clk);
        cmdValid <= 1'b0;
    endtask

    task automatic collect(int maxc);
        nGot = 0;
        for (int k = 0; k < maxc; k++) begin
            @(negedge clk);
            if (rspValid === 1'b1) got[nGot++] = rspByte;
            sawTo = (rspTimeout === 1'b1);
            if (sawTo || rspLast === 1'b1) break;
        end
    endtask

    task automatic cmpGot();
        `CHK(nGot, exp.size())
        foreach (exp[i]) `CHK(got[i], exp[i])
    endtask

    task automatic t_read(logic [16:0] r, word_t n);
        word_t off, v;
        off = 16'(r - 17'd40001);
        exp = {8'h05, 8'h03, 8'(n * 2)};
        for (int i = 0; i < n; i++) begin
            v = rdf(off + 16'(i));
            exp.push_back(v[15:8]);
            exp.push_back(v[7:0]);
        end
        addCrc();
        cmd(8'h03, 8'h05, r, n);
        collect(3000);
        cmpGot();
        `CHK(rspCrcOk, 1'b1)
        $display("read test done");
    endtask

    task automatic t_write();
        exp = {8'h05, 8'h06, 8'h00, 8'h0D, 8'h17, 8'h70, 8'h17, 8'h99};
        wrCnt = 0;
        cmd(8'h06, 8'h05, 17'd40014, 16'h1770);
        collect(3000);
        cmpGot();
        `CHK(wrCnt, 1)
        `CHK(wrA, 16'h000D)
        `CHK(wrD, 16'h1770)
        cmd(8'h06, 8'h00, 17'd40020, 16'h1234);
        collect(2700);
        `CHK(nGot, 0)
        `CHK(wrA, 16'h0013)
        cmd(8'h06, 8'h05, 17'd41000, 16'hBEEF);
        collect(3000);
        `CHK(sawTo, 1'b1)
        `CHK(wrCnt, 2)
        $display("write test done");
    endtask

    task automatic t_diag_foreign();
        mk(8'h05, 8'h08, 16'h0000, 16'hFFFF);
        cmd(8'h08, 8'h05, 17'd0, 16'hFFFF);
        collect(3000);
        cmpGot();
        cmd(8'h03, 8'h11, 17'd40001, 16'h0001);
        collect(3000);
        `CHK(nGot, 0)
        `CHK(sawTo, 1'b1)
        $display("echo test done");
    endtask

    task automatic t_reject();
        bit rj;
        for (int i = 0; i < 4; i++) begin
            cmd(i == 3 ? 8'h10 : 8'h03, i == 0 ? 8'h00 : 8'h05, 17'd40001,
                i == 1 ? 16'h0000 : i == 2 ? 16'h007E : 16'h0001);
            rj = 0;
            repeat (3) @(negedge clk) rj |= (cmdReject === 1'b1);
            `CHK(rj, 1'b1)
        end
        $display("reject test done");
    endtask

    // Raw frame into the second slave, then count reply bytes
    task automatic raw(byte_t a, f, word_t w1, w2, bit bad, int n);
        mk(a, f, w1, w2);
        if (bad) exp[6] = ~exp[6];
        r2Cnt = 0;
        @(posedge clk);
        foreach (exp[i]) begin
            link2.qValid <= 1'b1;
            link2.qData <= exp[i];
            link2.qLast <= (i == 7);
            for (int k = 0; k < 400; k++) begin
                @(negedge clk);
                if (link2.qReady === 1'b1) break;
            end
            @(posedge clk);
        end
        link2.qValid <= 1'b0;
        link2.qLast <= 1'b0;
        repeat (300) @(posedge clk);
        `CHK(r2Cnt, n)
    endtask

    task automatic t_fifo();
        int m;
        m = 0;
        link2.rReady <= 1'b0;
        raw(8'h05, 8'h08, 16'h0000, 16'h1357, 0, 0);
        `CHK(link2.rValid, 1'b1)
        `CHK(link2.rData, exp[0])
        link2.rReady <= 1'b1;
        repeat (9) begin
            @(negedge clk);
            if (link2.rValid === 1'b1) `CHK(link2.rData, exp[m++])
        end
        `CHK(m, 8)
        $display("buffer test done");
    endtask

    // Main sequence
    initial begin
        rst_n = 0;
        cmdValid = 0;
        link2.qValid = 0;
        link2.qData = 0;
        link2.qLast = 0;
        link2.rReady = 1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_read(17'd41004, 16'd3);
        t_read(17'd40001, 16'd125);
        t_write();
        t_diag_foreign();
        t_reject();
        raw(8'h05, 8'h08, 16'h0000, 16'hABCD, 0, 8);
        raw(8'h05, 8'h08, 16'h0000, 16'hABCD, 1, 0);
        raw(8'h00, 8'h08, 16'h0000, 16'hABCD, 0, 0);
        raw(8'h00, 8'h03, 16'h0000, 16'h0001, 0, 0);
        raw(8'h05, 8'h08, 16'h0001, 16'hABCD, 0, 0);
        raw(8'h05, 8'h03, 16'h0000, 16'h007E, 0, 0);
        raw(8'h22, 8'h08, 16'h0000, 16'hABCD, 0, 0);
        $display("raw test done");
        t_fifo();
        tally_and_finish();
    end
endmodule

// *** verilog/modbus_byte_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock; width and depth set by parameters.
`timescale 1ns/1ps
module modbus_byte_fifo #(
    parameter int W = 9,
    parameter int D = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inValid,
    input wire logic [W-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [W-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wrPtrQ;
    logic [AW-1:0] rdPtrQ;
    logic [CW-1:0] cntQ;
    logic doWr;
    logic doRd;

    // Honest full and empty from the occupancy count
    assign inReady = (cntQ != CW'(D));
    assign outValid = (cntQ != '0);
    assign outData = mem[rdPtrQ];
    assign doWr = inValid & inReady;
    assign doRd = outValid & outReady;

    // Storage array
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtrQ] <= inData;
        end
    end

    // Pointers and count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtrQ <= '0;
            rdPtrQ <= '0;
            cntQ <= '0;
        end else begin
            if (doWr) begin
                wrPtrQ <= (wrPtrQ == AW'(D - 1)) ? '0 : wrPtrQ + 1'b1;
            end
            if (doRd) begin
                rdPtrQ <= (rdPtrQ == AW'(D - 1)) ? '0 : rdPtrQ + 1'b1;
            end
            cntQ <= cntQ + CW'(doWr) - CW'(doRd);
        end
    end
endmodule

// *** verilog/modbus_link_if.sv ***
// Byte-stream link between the query master and the register slave.
// Assumes both ends run on the clock and reset carried here.
`timescale 1ns/1ps
interface modbus_link_if (
    input wire logic clk,
    input wire logic rst_n
);
    // Query bytes, master to slave
    logic qValid;
    logic [7:0] qData;
    logic qLast;
    logic qReady;
    // Response bytes, slave to master
    logic rValid;
    logic [7:0] rData;
    logic rLast;
    logic rReady;

    modport master (
        input clk, rst_n, qReady, rValid, rData, rLast,
        output qValid, qData, qLast, rReady
    );
    modport slave (
        input clk, rst_n, qValid, qData, qLast, rReady,
        output qReady, rValid, rData, rLast
    );
endinterface

// *** verilog/modbus_master_end.sv ***
// Query master end: builds eight-byte queries and collects replies.
// Assumes the slave end on the same clock through the link.
`timescale 1ns/1ps
module modbus_master_end (
    modbus_link_if.master link,
    input wire logic cmdValid,
    input wire modbus_pkg::byte_t cmdFunc,
    input wire modbus_pkg::byte_t cmdSlave,
    input wire logic [16:0] cmdReg,
    input wire modbus_pkg::word_t cmdArg,
    output logic cmdReady,
    output logic cmdReject,
    output logic rspValid,
    output modbus_pkg::byte_t rspByte,
    output logic rspLast,
    output logic rspCrcOk,
    output logic rspTimeout
);
    import modbus_pkg::*;

    typedef enum logic [1:0] {
        M_IDLE = 2'h0,
        M_SEND = 2'h1,
        M_WAIT = 2'h2,
        M_GAP = 2'h3
    } mstate_t;

    mstate_t stateQ;
    byte_t txBuf [6];
    logic [3:0] idxQ;
    word_t txCrcQ;
    word_t rxCrcQ;
    logic [11:0] timerQ;
    logic bcastQ;
    logic qValidQ;
    byte_t qDataQ;
    logic qLastQ;
    logic cmdReadyQ;
    logic rejectQ;
    logic rspValidQ;
    byte_t rspByteQ;
    logic rspLastQ;
    logic rspCrcOkQ;
    logic timeoutQ;

    logic clk;
    logic rst_n;
    logic badCmd;
    logic accept;
    word_t offset;
    byte_t nextByte;
    logic canLoad;
    logic rxTake;
    word_t rxCrcNext;

    assign clk = link.clk;
    assign rst_n = link.rst_n;

    // Command screening and wire offset
    assign badCmd = ((cmdFunc == FC_READ) && ((cmdSlave == BCAST_ADDR)
        || (cmdArg == 16'h0000) || (cmdArg > MAX_READ_REGS)))
        || ((cmdFunc == FC_DIAG) && (cmdSlave == BCAST_ADDR))
        || !((cmdFunc == FC_READ) || (cmdFunc == FC_WRITE)
        || (cmdFunc == FC_DIAG));
    assign accept = (stateQ == M_IDLE) && cmdValid && !badCmd;
    assign offset = (cmdFunc == FC_DIAG) ? DIAG_SUB_ECHO
        : 16'(cmdReg - HOLD_REG_BASE);

    // Query byte selection and link handshakes
    assign nextByte = (idxQ == CRC_LO_IDX) ? txCrcQ[7:0] :
        (idxQ == CRC_HI_IDX) ? txCrcQ[15:8] : txBuf[idxQ[2:0]];
    assign canLoad = !qValidQ || link.qReady;
    assign rxTake = link.rValid && (stateQ == M_WAIT);
    assign rxCrcNext = crc16Next(rxCrcQ, link.rData);

    // Latched query fields: addr, func, offset, count or data
    always_ff @(posedge clk) begin
        if (accept) begin
            txBuf[0] <= cmdSlave;
            txBuf[1] <= cmdFunc;
            txBuf[2] <= offset[15:8];
            txBuf[3] <= offset[7:0];
            txBuf[4] <= cmdArg[15:8];
            txBuf[5] <= cmdArg[7:0];
        end
    end

    // Sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stateQ <= M_IDLE;
            idxQ <= 4'h0;
            txCrcQ <= CRC_INIT;
            rxCrcQ <= CRC_INIT;
            timerQ <= 12'h000;
            bcastQ <= 1'b0;
            qValidQ <= 1'b0;
            qDataQ <= 8'h00;
            qLastQ <= 1'b0;
            cmdReadyQ <= 1'b0;
            rejectQ <= 1'b0;
            rspValidQ <= 1'b0;
            rspByteQ <= 8'h00;
            rspLastQ <= 1'b0;
            rspCrcOkQ <= 1'b0;
            timeoutQ <= 1'b0;
        end else begin
            rejectQ <= (stateQ == M_IDLE) && cmdValid && badCmd;
            rspValidQ <= rxTake;
            rspLastQ <= rxTake && link.rLast;
            timeoutQ <= 1'b0;
            cmdReadyQ <= (stateQ == M_IDLE) && !cmdValid;
            if (rxTake) begin
                rspByteQ <= link.rData;
                rxCrcQ <= rxCrcNext;
                rspCrcOkQ <= (rxCrcNext == CRC_RESIDUE);
            end
            unique case (stateQ)
                M_IDLE: begin
                    if (accept) begin
                        stateQ <= M_SEND;
                        idxQ <= 4'h0;
                        txCrcQ <= CRC_INIT;
                        bcastQ <= (cmdSlave == BCAST_ADDR);
                    end
                end
                M_SEND: begin
                    if (canLoad && (idxQ != FRAME_LEN)) begin
                        qValidQ <= 1'b1;
                        qDataQ <= nextByte;
                        qLastQ <= (idxQ == CRC_HI_IDX);
                        idxQ <= idxQ + 4'h1;
                        if (idxQ < CRC_LO_IDX) begin
                            txCrcQ <= crc16Next(txCrcQ, nextByte);
                        end
                    end else if (canLoad) begin
                        qValidQ <= 1'b0;
                        qLastQ <= 1'b0;
                        rxCrcQ <= CRC_INIT;
                        stateQ <= bcastQ ? M_GAP : M_WAIT;
                        timerQ <= bcastQ ? BCAST_GAP_CYC
                            : RSP_TIMEOUT_CYC;
                    end
                end
                M_WAIT: begin
                    timerQ <= timerQ - 12'h001;
                    if (rxTake && link.rLast) begin
                        stateQ <= M_IDLE;
                    end else if (timerQ == 12'h000) begin
                        timeoutQ <= 1'b1;
                        stateQ <= M_IDLE;
                    end
                end
                M_GAP: begin
                    timerQ <= timerQ - 12'h001;
                    if (timerQ == 12'h000) begin
                        stateQ <= M_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.qValid = qValidQ;
    assign link.qData = qDataQ;
    assign link.qLast = qLastQ;
    assign link.rReady = 1'b1;
    assign cmdReady = cmdReadyQ;
    assign cmdReject = rejectQ;
    assign rspValid = rspValidQ;
    assign rspByte = rspByteQ;
    assign rspLast = rspLastQ;
    assign rspCrcOk = rspCrcOkQ;
    assign rspTimeout = timeoutQ;
endmodule

// *** verilog/modbus_pkg.sv ***
// Shared constants, types and the frame check for the query link.
// Assumes one 25 MHz clock shared by both ends of the link.
package modbus_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [15:0] word_t;

    // Function codes and addressing
    localparam byte_t FC_READ = 8'h03;
    localparam byte_t FC_WRITE = 8'h06;
    localparam byte_t FC_DIAG = 8'h08;
    localparam byte_t BCAST_ADDR = 8'h00;
    localparam word_t DIAG_SUB_ECHO = 16'h0000;
    localparam logic [16:0] HOLD_REG_BASE = 17'h09C41; // 40001 decimal
    localparam word_t MAX_READ_REGS = 16'h007D; // 125 registers

    // Frame layout: every supported query is eight bytes
    localparam logic [3:0] FRAME_LEN = 4'h8;
    localparam logic [3:0] FRAME_OVER = 4'h9;
    localparam logic [3:0] CRC_LO_IDX = 4'h6;
    localparam logic [3:0] CRC_HI_IDX = 4'h7;
    localparam word_t CRC_INIT = 16'hFFFF;
    localparam word_t CRC_POLY = 16'hA001;
    localparam word_t CRC_RESIDUE = 16'h0000;

    // Response buffer shape
    localparam int FIFO_WIDTH = 9;
    localparam int FIFO_DEPTH = 4;

    // Timing at 25 MHz
    localparam int CLK_MHZ = 25;
    localparam int BCAST_GAP_US = 100;
    localparam int RSP_TIMEOUT_US = 100;
    localparam logic [11:0] BCAST_GAP_CYC = 12'(BCAST_GAP_US * CLK_MHZ);
    localparam logic [11:0] RSP_TIMEOUT_CYC = 12'(RSP_TIMEOUT_US * CLK_MHZ);

    // One byte step of the frame check, reflected polynomial
    function automatic word_t crc16Next(word_t c, byte_t b);
        word_t x;
        x = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

endpackage

// *** verilog/modbus_slave_end.sv ***
// Register slave end: checks queries, runs read, write and echo.
// Assumes the link carries whole frames marked by a last flag and
// that the user side answers reads combinationally from regAddr.
//
// Contract
// - Read query: addr, 03, start, count, check
// - Wire offset is register number minus 40001
// - Read count at most 125 registers
// - No broadcast for read or diagnostic
// - Read reply byte count is twice count
// - Reply words high byte first, ascending
// - Reads reach every holding register area
// - Single writes only to writable areas
// - Write query: addr, 06, offset, data, check
// - Write offset is register number minus 40001
// - Broadcast write is performed by all
// - Addressed write reply echoes the query
// - Never reply to a broadcast
// - Master waits processing time after broadcast
// - Diagnostic: 08, subfunction 0000, any data
// - Diagnostic reply echoes the query unchanged
// - Frame check sent low byte first
// - Frames failing the check are erroneous
`timescale 1ns/1ps
module modbus_slave_end (
    modbus_link_if.slave link,
    input wire modbus_pkg::byte_t ownAddr,
    output modbus_pkg::word_t regAddr,
    input wire modbus_pkg::word_t rdData,
    input wire logic wrAllow,
    output logic wrEn,
    output modbus_pkg::word_t wrData
);
    import modbus_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_CHECK = 4'h1,
        S_WCHK = 4'h2,
        S_HEAD = 4'h3,
        S_LOAD = 4'h4,
        S_DATA = 4'h5,
        S_CRCL = 4'h6,
        S_CRCH = 4'h7,
        S_ECHO = 4'h8
    } state_t;

    state_t stateQ;
    state_t stateD;
    byte_t rxBuf [8];
    logic [3:0] rxCntQ;
    word_t rxCrcQ;
    word_t txCrcQ;
    logic [3:0] idxQ;
    logic [6:0] regsLeftQ;
    word_t wordQ;
    word_t regAddrQ;
    logic wrEnQ;
    word_t wrDataQ;
    logic qReadyQ;

    logic clk;
    logic rst_n;
    logic rxTake;
    byte_t slv;
    byte_t fc;
    word_t fieldA;
    word_t fieldB;
    logic isBcast;
    logic frameOk;
    logic readOk;
    logic diagOk;
    byte_t byteCount;
    byte_t headByte;
    byte_t dataByte;
    byte_t emitByte;
    logic emitValid;
    logic emitLast;
    logic fifoReady;
    logic push;

    assign clk = link.clk;
    assign rst_n = link.rst_n;

    // Query field decode from the receive buffer
    assign rxTake = link.qValid & qReadyQ;
    assign slv = rxBuf[0];
    assign fc = rxBuf[1];
    assign fieldA = {rxBuf[2], rxBuf[3]};
    assign fieldB = {rxBuf[4], rxBuf[5]};
    assign isBcast = (slv == BCAST_ADDR);
    assign frameOk = (rxCntQ == FRAME_LEN) && (rxCrcQ == CRC_RESIDUE)
        && ((slv == ownAddr) || isBcast);
    assign readOk = (fc == FC_READ) && !isBcast
        && (fieldB != 16'h0000) && (fieldB <= MAX_READ_REGS);
    assign diagOk = (fc == FC_DIAG) && !isBcast
        && (fieldA == DIAG_SUB_ECHO);

    // Response byte selection
    assign byteCount = {fieldB[6:0], 1'b0};
    assign headByte = (idxQ == 4'h0) ? slv :
        (idxQ == 4'h1) ? FC_READ : byteCount;
    assign dataByte = idxQ[0] ? wordQ[7:0] : wordQ[15:8];
    assign emitByte = (stateQ == S_HEAD) ? headByte :
        (stateQ == S_DATA) ? dataByte :
        (stateQ == S_CRCL) ? txCrcQ[7:0] :
        (stateQ == S_CRCH) ? txCrcQ[15:8] :
        rxBuf[idxQ[2:0]];
    assign emitValid = (stateQ == S_HEAD) || (stateQ == S_DATA)
        || (stateQ == S_CRCL) || (stateQ == S_CRCH) || (stateQ == S_ECHO);
    assign emitLast = (stateQ == S_CRCH)
        || ((stateQ == S_ECHO) && (idxQ == CRC_HI_IDX));
    assign push = emitValid & fifoReady;

    // Next state
    always_comb begin
        stateD = stateQ;
        unique case (stateQ)
            S_IDLE: begin
                if (rxTake && link.qLast) begin
                    stateD = S_CHECK;
                end
            end
            S_CHECK: begin
                if (!frameOk) begin
                    stateD = S_IDLE;
                end else if (readOk) begin
                    stateD = S_HEAD;
                end else if (fc == FC_WRITE) begin
                    stateD = S_WCHK;
                end else if (diagOk) begin
                    stateD = S_ECHO;
                end else begin
                    stateD = S_IDLE;
                end
            end
            S_WCHK: begin
                stateD = (wrAllow && !isBcast) ? S_ECHO : S_IDLE;
            end
            S_HEAD: begin
                if (push && (idxQ == 4'h2)) begin
                    stateD = S_LOAD;
                end
            end
            S_LOAD: begin
                stateD = S_DATA;
            end
            S_DATA: begin
                if (push && idxQ[0]) begin
                    stateD = (regsLeftQ == 7'h01) ? S_CRCL : S_LOAD;
                end
            end
            S_CRCL: begin
                if (push) begin
                    stateD = S_CRCH;
                end
            end
            S_CRCH: begin
                if (push) begin
                    stateD = S_IDLE;
                end
            end
            S_ECHO: begin
                if (push && (idxQ == CRC_HI_IDX)) begin
                    stateD = S_IDLE;
                end
            end
            default: begin
                stateD = S_IDLE;
            end
        endcase
    end

    // Receive buffer data, kept for the echo reply
    always_ff @(posedge clk) begin
        if (rxTake && (rxCntQ < FRAME_LEN)) begin
            rxBuf[rxCntQ[2:0]] <= link.qData;
        end
    end

    // Receive count and running frame check
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxCntQ <= 4'h0;
            rxCrcQ <= CRC_INIT;
        end else if (rxTake) begin
            rxCntQ <= (rxCntQ == FRAME_OVER) ? FRAME_OVER : rxCntQ + 4'h1;
            rxCrcQ <= crc16Next(rxCrcQ, link.qData);
        end else if (stateQ != S_IDLE) begin
            rxCntQ <= 4'h0;
            rxCrcQ <= CRC_INIT;
        end
    end

    // Sequencer, reply check and register access
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stateQ <= S_IDLE;
            idxQ <= 4'h0;
            txCrcQ <= CRC_INIT;
            regsLeftQ <= 7'h00;
            wordQ <= 16'h0000;
            regAddrQ <= 16'h0000;
            wrEnQ <= 1'b0;
            wrDataQ <= 16'h0000;
            qReadyQ <= 1'b0;
        end else begin
            stateQ <= stateD;
            idxQ <= (stateD != stateQ) ? 4'h0 : idxQ + 4'(push);
            qReadyQ <= (stateD == S_IDLE);
            wrEnQ <= (stateQ == S_WCHK) && wrAllow;
            if (stateQ == S_CHECK) begin
                txCrcQ <= CRC_INIT;
                regAddrQ <= fieldA;
                regsLeftQ <= fieldB[6:0];
                wrDataQ <= fieldB;
            end else if (push && (stateQ != S_CRCL)) begin
                txCrcQ <= crc16Next(txCrcQ, emitByte);
            end
            if (stateQ == S_LOAD) begin
                wordQ <= rdData;
            end
            if ((stateQ == S_DATA) && push && idxQ[0]) begin
                regAddrQ <= regAddrQ + 16'h0001;
                regsLeftQ <= regsLeftQ - 7'h01;
            end
        end
    end

    assign regAddr = regAddrQ;
    assign wrEn = wrEnQ;
    assign wrData = wrDataQ;
    assign link.qReady = qReadyQ;

    // Response buffer towards the link
    modbus_byte_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) respFifo (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(emitValid),
        .inData({emitLast, emitByte}),
        .inReady(fifoReady),
        .outValid(link.rValid),
        .outData({link.rLast, link.rData}),
        .outReady(link.rReady)
    );
endmodule
